// ==== vulf_core.v ====
// Summary of operation
// [R1] Over-voltage warning threshold at code 0x42.
// [R2] Under-voltage warning threshold at code 0x43.
// [R3] Under-voltage fault threshold at code 0x44.
// [R4] Response 00: keep regulating on fault.
// [R5] Response 01: run delay, then apply retries.
// [R6] Response 10: disable at once, then retry.
// [R7] Response 11: off only while fault persists.
// [R8] Retry 000: no restart, stay off.
// [R9] Retry 1..6: that many restarts, then off.
// [R10] Retry 111: endless until off or fault.
// [R11] Restart starts spaced by the delay.
// [R12] Delay field n gives 2^n units.
// [R13] One delay for grace and restart spacing.
// [R14] Unit length comes from external 0xD2 setting.
// [R15] Compare output voltage against each threshold.
`timescale 1ns/1ps
`include "vulf_defines.vh"

module vulf_core
#(
  parameter UNIT_W = 24
)
(
  input  wire                   ref_clk,
  input  wire                   nrst,
  input  wire                   regWrEn,
  input  wire                   regRdEn,
  input  wire [7:0]             regCode,
  input  wire [15:0]            regWrData,
  output reg  [15:0]            regRdData,
  output reg                    regRdValid,
  input  wire [`VULF_THR_W-1:0] voutMeas,
  input  wire [UNIT_W-1:0]      unitCycles,
  input  wire                   runCmd,
  input  wire                   otherFault,
  input  wire                   clearFaults,
  output reg                    outEnable,
  output reg                    ovWarn,
  output reg                    uvWarn,
  output reg                    uvFault,
  output reg                    faultLatched,
  output reg                    retrying
);

  // ----------------------------------------------------------------------
  // State encoding of the fault sequencer.
  // ----------------------------------------------------------------------
  localparam [6:0] ST_IDLE  = 7'h01; // Commanded off.
  localparam [6:0] ST_RUN   = 7'h02; // Regulating normally.
  localparam [6:0] ST_GRACE = 7'h04; // Running through the grace delay.
  localparam [6:0] ST_HOLD  = 7'h08; // Off, waiting before first restart.
  localparam [6:0] ST_TRY   = 7'h10; // Restart attempt in progress.
  localparam [6:0] ST_OFFOK = 7'h20; // Off until the fault goes away.
  localparam [6:0] ST_LATCH = 7'h40; // Off until the fault is cleared.

  // ----------------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------------
  reg [`VULF_THR_W-1:0]   ovWarnThr_reg;  // Over-voltage warning level.
  reg [`VULF_THR_W-1:0]   uvWarnThr_reg;  // Under-voltage warning level.
  reg [`VULF_THR_W-1:0]   uvFaultThr_reg; // Under-voltage fault level.
  reg [`VULF_RESP_W-1:0]  uvResp_reg;     // Reaction configuration.
  reg [6:0]               state_reg;      // Sequencer state.
  reg [6:0]               state_next;     // Next sequencer state.
  reg [2:0]               attempt_reg;    // Restarts made so far.
  reg [2:0]               attempt_next;   // Next restart count.
  reg                     outEn_next;     // Next output enable.
  reg                     timerLoad;      // Starts a fresh delay.
  reg [UNIT_W-1:0]        prescale_reg;   // Cycles left in this unit.
  reg [`VULF_UNITS_W-1:0] unitsLeft_reg;  // Units left in the delay.
  reg                     timerRun_reg;   // Delay is counting.

  // Field views of the reaction register.
  wire [1:0] respMode  = uvResp_reg[`VULF_RESP_HI:`VULF_RESP_LO];
  wire [2:0] retryCfg  = uvResp_reg[`VULF_RETRY_HI:`VULF_RETRY_LO];
  wire [2:0] delaySel  = uvResp_reg[`VULF_DLY_HI:`VULF_DLY_LO];
  // The unit tick fires as the last cycle of each unit ends.
  wire       unitTick  = timerRun_reg && (prescale_reg == {UNIT_W{1'b0}});
  // The delay has ended once the final unit ticks away.
  wire       timerDone = unitTick && (unitsLeft_reg == `VULF_ONE_UNIT);

  // Tells whether another restart is allowed after a given count.
  function retryAllowed;
    input [2:0] cfg;
    input [2:0] used;
    retryAllowed = (cfg == `VULF_RETRY_ENDLESS) || (used < cfg);
  endfunction
  // Chooses the state after the output has been shut for a fault.
  function [6:0] afterShutdown;
    input [2:0] cfg;
    afterShutdown = (cfg == `VULF_RETRY_NONE) ? ST_LATCH : ST_HOLD;
  endfunction

  // ----------------------------------------------------------------------
  // Register port and threshold comparators.
  // ----------------------------------------------------------------------
  // Each code stores its value; unknown codes are ignored.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ovWarnThr_reg  <= `VULF_RST_OV_WARN;
      uvWarnThr_reg  <= `VULF_RST_UV_WARN;
      uvFaultThr_reg <= `VULF_RST_UV_FAULT;
      uvResp_reg     <= `VULF_RST_UV_RESP;
    end
    else if (regWrEn)
    begin
      case (regCode)
        // [R1] over-voltage warning store
        `VULF_CODE_OV_WARN:  ovWarnThr_reg  <= regWrData;
        // [R2] under-voltage warning store
        `VULF_CODE_UV_WARN:  uvWarnThr_reg  <= regWrData;
        // [R3] under-voltage fault store
        `VULF_CODE_UV_FAULT: uvFaultThr_reg <= regWrData;
        // The reaction register keeps only its low byte.
        `VULF_CODE_UV_RESP:  uvResp_reg <= regWrData[`VULF_RESP_W-1:0];
        default:             uvResp_reg <= uvResp_reg;
      endcase
    end
  end

  // Read data follows one cycle after the request; unknown codes read zero.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regRdData  <= 16'h0000;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRdEn;
      if (regRdEn)
      begin
        case (regCode)
          `VULF_CODE_OV_WARN:  regRdData <= ovWarnThr_reg;
          `VULF_CODE_UV_WARN:  regRdData <= uvWarnThr_reg;
          `VULF_CODE_UV_FAULT: regRdData <= uvFaultThr_reg;
          `VULF_CODE_UV_RESP:  regRdData <= {8'h00, uvResp_reg};
          default:             regRdData <= 16'h0000;
        endcase
      end
    end
  end

  // Flags are registered so that the sequencer sees a clean level.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ovWarn  <= 1'b0;
      uvWarn  <= 1'b0;
      uvFault <= 1'b0;
    end
    else
    begin
      // [R15] threshold comparisons
      ovWarn  <= (voutMeas > ovWarnThr_reg);
      uvWarn  <= (voutMeas < uvWarnThr_reg);
      uvFault <= (voutMeas < uvFaultThr_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Delay timer.
  // ----------------------------------------------------------------------
  // A load starts 2^n units; each unit lasts unitCycles clock cycles.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prescale_reg  <= {UNIT_W{1'b0}};
      unitsLeft_reg <= `VULF_ONE_UNIT;
      timerRun_reg  <= 1'b0;
    end
    else if (timerLoad)
    begin
      // [R14] unit length from outside
      prescale_reg  <= unitCycles - {{(UNIT_W-1){1'b0}}, 1'b1};
      // [R12] power-of-two unit count
      unitsLeft_reg <= `VULF_ONE_UNIT << delaySel;
      timerRun_reg  <= 1'b1;
    end
    else if (timerDone)
    begin
      // The delay is spent; the timer rests until loaded again.
      timerRun_reg  <= 1'b0;
    end
    else if (unitTick)
    begin
      // One unit has passed; start counting the next one.
      prescale_reg  <= unitCycles - {{(UNIT_W-1){1'b0}}, 1'b1};
      unitsLeft_reg <= unitsLeft_reg - `VULF_ONE_UNIT;
    end
    else if (timerRun_reg)
    begin
      // Count down the cycles of the current unit.
      prescale_reg  <= prescale_reg - {{(UNIT_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------------
  // Fault sequencer.
  // ----------------------------------------------------------------------
  // Command-off and other faults take priority over the fault reaction.
  always @*
  begin
    state_next   = state_reg;
    attempt_next = attempt_reg;
    outEn_next   = 1'b1;
    timerLoad    = 1'b0;
    if (!runCmd)
    begin
      // [R10] commanded off stops retries
      state_next   = ST_IDLE;
      outEn_next   = 1'b0;
      attempt_next = 3'h0;
    end
    else if (otherFault)
    begin
      // [R10] other fault stops retries
      state_next = ST_LATCH;
      outEn_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // Turning on begins a fresh run with no restarts counted.
          state_next   = ST_RUN;
          attempt_next = 3'h0;
        end
        ST_RUN:
        begin
          if (uvFault)
          begin
            case (respMode)
              // [R4] ignore the fault
              `VULF_RESP_IGNORE: state_next = ST_RUN;
              `VULF_RESP_DELAY:
              begin
                // [R13] grace uses the delay
                state_next = ST_GRACE;
                timerLoad  = 1'b1;
              end
              `VULF_RESP_RETRY:
              begin
                // [R6] shut down at once
                outEn_next   = 1'b0;
                state_next   = afterShutdown(retryCfg);
                timerLoad    = 1'b1;
                attempt_next = 3'h0;
              end
              default:
              begin
                // [R7] off while fault present
                outEn_next = 1'b0;
                state_next = ST_OFFOK;
              end
            endcase
          end
        end
        ST_GRACE:
        begin
          // [R5] act on retry setting
          if (timerDone)
          begin
            if (uvFault)
            begin
              outEn_next   = 1'b0;
              state_next   = afterShutdown(retryCfg);
              timerLoad    = 1'b1;
              attempt_next = 3'h0;
            end
            else
            begin
              state_next = ST_RUN;
            end
          end
        end
        ST_HOLD:
        begin
          // Output stays off for one delay, then the first restart starts.
          outEn_next = 1'b0;
          if (timerDone)
          begin
            // [R11] restart spacing
            state_next   = ST_TRY;
            timerLoad    = 1'b1;
            attempt_next = attempt_reg + 3'h1;
          end
        end
        ST_TRY:
        begin
          if (timerDone)
          begin
            if (!uvFault)
            begin
              // The restart worked; resume normal supervision.
              state_next   = ST_RUN;
              attempt_next = 3'h0;
            end
            // [R9] limited restart count
            else if (retryAllowed(retryCfg, attempt_reg))
            begin
              // [R11] next start one delay on
              outEn_next   = 1'b0;
              timerLoad    = 1'b1;
              attempt_next = (retryCfg == `VULF_RETRY_ENDLESS) ?
                             attempt_reg : attempt_reg + 3'h1;
            end
            else
            begin
              // All restarts spent; stay off until cleared.
              outEn_next = 1'b0;
              state_next = ST_LATCH;
            end
          end
        end
        ST_OFFOK:
        begin
          // [R7] resume when fault gone
          outEn_next = uvFault ? 1'b0 : 1'b1;
          state_next = uvFault ? ST_OFFOK : ST_RUN;
        end
        ST_LATCH:
        begin
          // [R8] off until fault cleared
          outEn_next = 1'b0;
          if (clearFaults)
          begin
            state_next   = ST_RUN;
            outEn_next   = 1'b1;
            attempt_next = 3'h0;
          end
        end
        default:
        begin
          // An illegal code falls back to the safe off state.
          state_next = ST_IDLE;
          outEn_next = 1'b0;
        end
      endcase
    end
  end

  // The enable, latch and retry outputs are flip-flops fed from the next-state logic.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= ST_IDLE;
      attempt_reg  <= 3'h0;
      outEnable    <= 1'b0;
      faultLatched <= 1'b0;
      retrying     <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      attempt_reg  <= attempt_next;
      outEnable    <= outEn_next;
      faultLatched <= (state_next == ST_LATCH);
      retrying     <= (state_next == ST_HOLD) || (state_next == ST_TRY);
    end
  end

endmodule

// ==== vulf_defines.vh ====
`ifndef VULF_DEFINES_VH
`define VULF_DEFINES_VH

// ----------------------------------------------------------------------
// Command codes of the supervision registers.
// ----------------------------------------------------------------------
`define VULF_CODE_OV_WARN    8'h42
`define VULF_CODE_UV_WARN    8'h43
`define VULF_CODE_UV_FAULT   8'h44
`define VULF_CODE_UV_RESP    8'h45

// ----------------------------------------------------------------------
// Reset values of the registers.
// ----------------------------------------------------------------------
`define VULF_RST_OV_WARN     16'hFFFF
`define VULF_RST_UV_WARN     16'h0000
`define VULF_RST_UV_FAULT    16'h0000
`define VULF_RST_UV_RESP     8'h00

// ----------------------------------------------------------------------
// Field positions of the under-voltage reaction register.
// ----------------------------------------------------------------------
`define VULF_RESP_HI         7
`define VULF_RESP_LO         6
`define VULF_RETRY_HI        5
`define VULF_RETRY_LO        3
`define VULF_DLY_HI          2
`define VULF_DLY_LO          0

// ----------------------------------------------------------------------
// Response codes and special retry counts.
// ----------------------------------------------------------------------
`define VULF_RESP_IGNORE     2'h0
`define VULF_RESP_DELAY      2'h1
`define VULF_RESP_RETRY      2'h2
`define VULF_RESP_RESUME     2'h3
`define VULF_RETRY_NONE      3'h0
`define VULF_RETRY_ENDLESS   3'h7

// ----------------------------------------------------------------------
// Widths and timer constants.
// ----------------------------------------------------------------------
`define VULF_THR_W           16
`define VULF_RESP_W          8
`define VULF_UNITS_W         8
`define VULF_ONE_UNIT        8'h01

`endif

// ==== vulf_core_props.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker of the supervision block.
// ------------------------------------------------------------
module vulf_core_props
(
  input wire        ref_clk,
  input wire        nrst,
  input wire        regWrEn,
  input wire        regRdEn,
  input wire [7:0]  regCode,
  input wire [15:0] regWrData,
  input wire        regRdValid,
  input wire [15:0] voutMeas,
  input wire        runCmd,
  input wire        otherFault,
  input wire        outEnable,
  input wire        ovWarn,
  input wire        uvWarn,
  input wire        uvFault,
  input wire        faultLatched,
  input wire        retrying
);
  reg [15:0] ovThr_reg;  // Shadow of the over-voltage warning level.
  reg [15:0] uwThr_reg;  // Shadow of the under-voltage warning level.
  reg [15:0] ufThr_reg;  // Shadow of the under-voltage fault level.
  reg [7:0]  resp_reg;   // Shadow of the reaction byte.

  // Shadows follow the writes so compares need no peeking inside.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ovThr_reg <= 16'hFFFF;
      uwThr_reg <= 16'h0000;
      ufThr_reg <= 16'h0000;
      resp_reg  <= 8'h00;
    end
    else if (regWrEn)
    begin
      if (regCode == 8'h42) ovThr_reg <= regWrData;
      if (regCode == 8'h43) uwThr_reg <= regWrData;
      if (regCode == 8'h44) ufThr_reg <= regWrData;
      if (regCode == 8'h45) resp_reg <= regWrData[7:0];
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Output running, fault seen, no other cause active.
  sequence s_run_fault;
    outEnable && uvFault && runCmd && !otherFault && !retrying
      && !faultLatched;
  endsequence

  a_read_answer: assert property (regRdEn |=> regRdValid)
    else $error("read not answered");
  a_valid_cause: assert property (regRdValid |-> $past(regRdEn))
    else $error("valid without read");
  a_ov_compare: assert property (
    ovWarn == ($past(voutMeas) > $past(ovThr_reg)))
    else $error("ovWarn wrong");
  a_uv_warn_cmp: assert property (
    uvWarn == ($past(voutMeas) < $past(uwThr_reg)))
    else $error("uvWarn wrong");
  a_uv_fault_cmp: assert property (
    uvFault == ($past(voutMeas) < $past(ufThr_reg)))
    else $error("uvFault wrong");
  a_ignore_keeps_on: assert property ((resp_reg[7:6] == 2'h0)
    && outEnable && runCmd && !otherFault && !retrying |=> outEnable)
    else $error("output dropped on ignored fault");
  a_disable_fast: assert property (
    resp_reg[7] ##0 s_run_fault |-> ##[1:2] !outEnable)
    else $error("output not disabled");
  a_retry_none: assert property (
    (resp_reg[7:3] == 5'h10) ##0 s_run_fault |-> ##[1:3] faultLatched)
    else $error("no latch without retries");
  a_resume_ok: assert property ((resp_reg[7:6] == 2'h3)
    && !outEnable && !uvFault && runCmd && !otherFault && !faultLatched
    |-> ##[1:2] outEnable)
    else $error("no resume after fault");
  a_latch_off: assert property (faultLatched |-> !outEnable)
    else $error("output on while latched");
  a_cmd_off: assert property (!runCmd ##1 !runCmd |=> !outEnable)
    else $error("output on while commanded off");
endmodule

bind vulf_core vulf_core_props vulf_core_props_inst
(
  .ref_clk      (ref_clk),
  .nrst         (nrst),
  .regWrEn      (regWrEn),
  .regRdEn      (regRdEn),
  .regCode      (regCode),
  .regWrData    (regWrData),
  .regRdValid   (regRdValid),
  .voutMeas     (voutMeas),
  .runCmd       (runCmd),
  .otherFault   (otherFault),
  .outEnable    (outEnable),
  .ovWarn       (ovWarn),
  .uvWarn       (uvWarn),
  .uvFault      (uvFault),
  .faultLatched (faultLatched),
  .retrying     (retrying)
);

// ==== vulf_plant.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Converter output model: the sense path lags one cycle.
// ------------------------------------------------------------
module vulf_plant
(
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire [15:0] targetVolt,
  output reg  [15:0] voutMeas
);
  // Registered sense keeps the measurement in the core's clock domain.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      voutMeas <= 16'h0000;
    else
      voutMeas <= targetVolt;
  end
endmodule

// ==== vulf_core_test.sv ====
`timescale 1ns/1ps
module vulf_core_test;
  reg         ref_clk;
  reg         nrst;
  reg         regWrEn;
  reg         regRdEn;
  reg  [7:0]  regCode;
  reg  [15:0] regWrData;
  wire [15:0] regRdData;
  wire        regRdValid;
  wire [15:0] voutMeas;
  reg  [23:0] unitCycles;
  reg         runCmd, otherFault, clearFaults, prevOn;
  reg  [15:0] targetVolt, ov, uw, uf, v;
  wire        outEnable, ovWarn, uvWarn, uvFault, faultLatched, retrying;
  integer     n_fail, comparisons, i, t, rises, tFall, tRise, dl;

  vulf_plant vulf_plant_inst (.ref_clk(ref_clk), .nrst(nrst),
    .targetVolt(targetVolt), .voutMeas(voutMeas));
  vulf_core vulf_core_inst (.ref_clk(ref_clk), .nrst(nrst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regCode(regCode),
    .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .voutMeas(voutMeas),
    .unitCycles(unitCycles), .runCmd(runCmd), .otherFault(otherFault),
    .clearFaults(clearFaults), .outEnable(outEnable), .ovWarn(ovWarn),
    .uvWarn(uvWarn), .uvFault(uvFault), .faultLatched(faultLatched),
    .retrying(retrying));

  always #5 ref_clk = ~ref_clk;

  task chk(input [15:0] seen, input [15:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task step(input integer k);
  begin
    repeat (k) @(posedge ref_clk);
    #1;
  end
  endtask

  task wr(input [7:0] c, input [15:0] d);
  begin
    regWrEn = 1'b1;
    regCode = c;
    regWrData = d;
    step(1);
    regWrEn = 1'b0;
    step(1);
  end
  endtask

  task rd(input [7:0] c, input [15:0] e);
  begin
    regRdEn = 1'b1;
    regCode = c;
    step(1);
    regRdEn = 1'b0;
    chk(regRdValid, 1'b1);
    chk(regRdData, e);
    step(1);
  end
  endtask

  // Restarts the unit in RUN with a fresh reaction byte and unit length.
  task prep(input [7:0] cfg);
  begin
    targetVolt = 16'h8000;
    unitCycles = 24'h2 + ($urandom % 3);
    wr(8'h42, 16'hFFFF);
    wr(8'h44, 16'h1000);
    wr(8'h45, {8'h00, cfg});
    runCmd = 1'b0;
    step(3);
    runCmd = 1'b1;
    step(4);
    chk(outEnable, 1'b1);
  end
  endtask

  // Persistent fault under shutdown-and-retry; counts and times restarts.
  task shutRun(input [2:0] rt, input [2:0] d, input integer lim);
  begin
    prep({2'h2, rt, d});
    dl = (1 << d) * unitCycles + 1;
    targetVolt = 16'h0100;
    rises = 0;
    tFall = -1;
    tRise = -1;
    prevOn = 1'b1;
    for (t = 0; t < lim && !faultLatched; t = t + 1)
    begin
      step(1);
      if (!outEnable && tFall < 0) tFall = t;
      if (outEnable && !prevOn)
      begin
        rises = rises + 1;
        if (tRise < 0) chk(t - tFall, dl);
        else chk(t - tRise, dl - 1);
        tRise = t;
      end
      prevOn = outEnable;
    end
  end
  endtask

  task conclude;
  begin
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  initial
  begin
    #800000;
    n_fail = n_fail + 1;
    conclude;
  end

  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    {regWrEn, regRdEn, otherFault, clearFaults} = 4'h0;
    regCode = 8'h00;
    regWrData = 16'h0000;
    unitCycles = 24'h2;
    runCmd = 1'b1;
    targetVolt = 16'h8000;
    n_fail = 0;
    comparisons = 0;
    i = $urandom(32'hFA1E);
    step(16);
    nrst = 1'b1;
    step(2);
    rd(8'h42, 16'hFFFF);
    rd(8'h43, 16'h0000);
    rd(8'h44, 16'h0000);
    rd(8'h45, 16'h0000);
    wr(8'h46, 16'h1234);
    rd(8'h46, 16'h0000);
    // random levels, readback and compares, sequencer held off
    runCmd = 1'b0;
    for (i = 0; i < 12; i = i + 1)
    begin
      {ov, uw, uf, v} = {$urandom, $urandom};
      wr(8'h42, ov);
      wr(8'h43, uw);
      wr(8'h44, uf);
      wr(8'h45, v);
      rd(8'h42, ov);
      rd(8'h43, uw);
      rd(8'h44, uf);
      rd(8'h45, {8'h00, v[7:0]});
      targetVolt = $urandom;
      step(3);
      chk(ovWarn, targetVolt > ov);
      chk(uvWarn, targetVolt < uw);
      chk(uvFault, targetVolt < uf);
    end
    for (i = 0; i < 7; i = i + 1)
    begin
      shutRun(i[2:0], $urandom % 3, 400);
      chk(rises, i);
      chk(faultLatched, 1'b1);
      chk(retrying, 1'b0);
      targetVolt = 16'h8000;
      step(3);
      clearFaults = 1'b1;
      step(1);
      clearFaults = 1'b0;
      step(4);
      chk(outEnable, 1'b1);
    end
    // endless retries end on command off
    shutRun(3'h7, 3'h0, 200);
    chk(rises > 5, 1'b1);
    chk(faultLatched, 1'b0);
    chk(retrying, 1'b1);
    runCmd = 1'b0;
    step(3);
    chk(outEnable, 1'b0);
    chk(retrying, 1'b0);
    // another fault shuts the unit down
    prep(8'hC0);
    otherFault = 1'b1;
    step(4);
    chk(outEnable, 1'b0);
    otherFault = 1'b0;
    // run through the delay, then latch
    prep({2'h1, 3'h0, 3'h2});
    dl = 4 * unitCycles + 1;
    targetVolt = 16'h0100;
    step(2);
    for (t = 0; t < 60 && outEnable; t = t + 1) step(1);
    chk(t >= dl - 1 && t <= dl + 2, 1'b1);
    step(3);
    chk(faultLatched, 1'b1);
    prep(8'h3F);
    targetVolt = 16'h0100;
    for (t = 0; t < 40; t = t + 1)
    begin
      step(1);
      chk(outEnable, 1'b1);
    end
    // off only while the fault lasts
    prep(8'hC0);
    targetVolt = 16'h0100;
    step(4);
    chk(outEnable, 1'b0);
    targetVolt = 16'h8000;
    step(5);
    chk(outEnable, 1'b1);
    chk(faultLatched, 1'b0);
    // reset in mid-run restores the defaults
    nrst = 1'b0;
    step(2);
    nrst = 1'b1;
    step(2);
    rd(8'h44, 16'h0000);
    chk(faultLatched, 1'b0);
    chk(outEnable, 1'b1);
    conclude;
  end
endmodule
